// ==== hw/axis_homing_supervisor.sv ====
// axis homing supervisor: motion gate, time limit, homing offset
`timescale 1ns/1ps
module axis_homing_supervisor #(
   parameter int unsigned SEC_TICKS = homing_pkg::SEC_CYCLES
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // configuration writes
   input wire homing_pkg::cfg_cmd_t CFG,
   input wire logic [1:0] QUERY_AXIS, // axis shown on readouts
   // per-axis mode inputs
   input wire logic [3:0] FORCE_REQUIRED, // internal homing-required causes
   input wire logic [3:0] REF_SEARCH_EN, // reference mark homing enabled
   input wire logic [3:0] MOVE_REQ, // motion requested per axis
   input wire homing_pkg::run_evt_t EVT [4],
   // outputs
   output logic [3:0] MOVE_EN,
   output logic [3:0] HOMED,
   output logic [3:0] REQUIRED_STS,
   output logic [3:0] TIMEOUT_FLAG,
   output logic [3:0] RUN_ACTIVE,
   output logic [3:0] SET_ORIGIN, // pulse: set origin and lower limit
   output logic [3:0] REF_SEARCH, // level: reference search phase
   output logic signed [18:0] OFS_TRAVEL, // offset + gap for QUERY_AXIS
   output logic [9:0] TMO_LIMIT, // limit of QUERY_AXIS
   output logic [9:0] TMO_LEFT, // remaining seconds of QUERY_AXIS
   output logic CFG_REJECT // pulse: value out of range
);
   import homing_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [3:0] gate_q, gate_d; // user gate settings
   logic [3:0] homed_q, homed_d;
   logic [3:0] tmo_q, tmo_d; // timeout flags
   logic [3:0] set_q, set_d;
   logic [9:0] lim_q [4], lim_d [4];
   logic [9:0] left_q [4], left_d [4];
   logic signed [17:0] ofs_q [4], ofs_d [4];
   run_st_t st_q [4], st_d [4];
   logic [31:0] tick_cnt_q, tick_cnt_d; // second divider
   logic tick_q, tick_d;
   logic rej_d, rej_q;
   logic [3:0] req_eff; // effective homing-required

   // ------------------------------------------------------------
   // one-second enable pulse
   // ------------------------------------------------------------
   always_comb begin
      tick_d = 1'b0;
      tick_cnt_d = tick_cnt_q + 32'h1;
      if (tick_cnt_q >= SEC_TICKS - 1) begin
         tick_cnt_d = '0;
         tick_d = 1'b1;
      end
   end

   // internal causes win over the user gate
   assign req_eff = gate_q | FORCE_REQUIRED;

   // ------------------------------------------------------------
   // config and run sequencing
   // ------------------------------------------------------------
   always_comb begin
      gate_d = gate_q;
      homed_d = homed_q;
      tmo_d = tmo_q;
      set_d = '0;
      rej_d = 1'b0;
      for (int i = 0; i < NUM_AXES; i++) begin
         lim_d[i] = lim_q[i];
         left_d[i] = left_q[i];
         ofs_d[i] = ofs_q[i];
         st_d[i] = st_q[i];
      end
      // configuration write to one axis
      if (CFG.gate_we) begin
         gate_d[CFG.axis] = CFG.gate_val;
      end
      if (CFG.tmo_we) begin
         if (CFG.tmo_val >= TMO_MIN_S && CFG.tmo_val <= TMO_MAX_S) begin
            lim_d[CFG.axis] = CFG.tmo_val;
         end else begin
            rej_d = 1'b1;
         end
      end
      if (CFG.ofs_we) begin
         if (CFG.ofs_val >= OFS_MIN_UM && CFG.ofs_val <= OFS_MAX_UM) begin
            ofs_d[CFG.axis] = CFG.ofs_val;
         end else begin
            rej_d = 1'b1;
         end
      end
      for (int i = 0; i < NUM_AXES; i++) begin
         case (st_q[i])
            IDLE: begin
               // a new run loads this axis's own limit
               if (EVT[i].start_home || EVT[i].start_range) begin
                  left_d[i] = lim_q[i];
                  tmo_d[i] = 1'b0;
                  st_d[i] = EVT[i].start_home ? LEAVE : RANGE;
               end
            end
            LEAVE: begin
               if (EVT[i].switch_released) begin
                  st_d[i] = OFFSET;
               end
            end
            OFFSET: begin
               // offset travelled first, then origin or reference search
               if (EVT[i].offset_reached) begin
                  if (REF_SEARCH_EN[i]) begin
                     st_d[i] = REFSRCH;
                  end else begin
                     set_d[i] = 1'b1;
                     homed_d[i] = 1'b1;
                     st_d[i] = IDLE;
                  end
               end
            end
            REFSRCH: begin
               if (EVT[i].done) begin
                  set_d[i] = 1'b1;
                  homed_d[i] = 1'b1;
                  st_d[i] = IDLE;
               end
            end
            RANGE: begin
               if (EVT[i].done) begin
                  st_d[i] = IDLE;
               end
            end
            default: st_d[i] = IDLE;
         endcase
         // countdown, stop and flag on expiry; left value stays after end
         if (st_q[i] != IDLE && tick_q) begin
            if (left_q[i] <= 10'h001) begin
               left_d[i] = '0;
               tmo_d[i] = 1'b1;
               st_d[i] = IDLE;
               set_d[i] = 1'b0;
               homed_d[i] = homed_q[i];
            end else begin
               left_d[i] = left_q[i] - 10'h001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         gate_q <= '0;
         homed_q <= '0;
         tmo_q <= '0;
         set_q <= '0;
         rej_q <= 1'b0;
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
         for (int i = 0; i < NUM_AXES; i++) begin
            lim_q[i] <= (i < 2) ? TMO_RST_XY_S : TMO_RST_ZA_S;
            left_q[i] <= '0;
            ofs_q[i] <= OFS_RST_UM;
            st_q[i] <= IDLE;
         end
      end else begin
         gate_q <= gate_d;
         homed_q <= homed_d;
         tmo_q <= tmo_d;
         set_q <= set_d;
         rej_q <= rej_d;
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
         for (int i = 0; i < NUM_AXES; i++) begin
            lim_q[i] <= lim_d[i];
            left_q[i] <= left_d[i];
            ofs_q[i] <= ofs_d[i];
            st_q[i] <= st_d[i];
         end
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         MOVE_EN <= '0;
         HOMED <= '0;
         REQUIRED_STS <= '0;
         TIMEOUT_FLAG <= '0;
         RUN_ACTIVE <= '0;
         SET_ORIGIN <= '0;
         REF_SEARCH <= '0;
         OFS_TRAVEL <= '0;
         TMO_LIMIT <= '0;
         TMO_LEFT <= '0;
         CFG_REJECT <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_AXES; i++) begin
            // active runs (homing or range-measure) always move; motion outside a run is gated
            MOVE_EN[i] <= MOVE_REQ[i] && (st_q[i] != IDLE || !req_eff[i] ||
                          homed_q[i]);
            RUN_ACTIVE[i] <= st_q[i] != IDLE;
            REF_SEARCH[i] <= st_q[i] == REFSRCH;
         end
         HOMED <= homed_q;
         REQUIRED_STS <= req_eff;
         TIMEOUT_FLAG <= tmo_q;
         SET_ORIGIN <= set_q;
         // a negative offset eats into the gap
         OFS_TRAVEL <= 19'(ofs_q[QUERY_AXIS]) + 19'(GAP_UM);
         TMO_LIMIT <= lim_q[QUERY_AXIS];
         TMO_LEFT <= left_q[QUERY_AXIS];
         CFG_REJECT <= rej_q;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_gate_blocks;
      @(posedge CLK) disable iff (RESET)
      (!RESET && req_eff[1] && !homed_q[1] && st_q[1] == IDLE) |=> !MOVE_EN[1];
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) else $error("unhomed gated axis moved");
   property p_gate_open;
      @(posedge CLK) disable iff (RESET)
      (!RESET && !req_eff[1] && MOVE_REQ[1]) |=> MOVE_EN[1];
   endproperty
   a_gate_open: assert property (p_gate_open) else $error("ungated axis blocked");
   property p_req_sts;
      @(posedge CLK) disable iff (RESET)
      FORCE_REQUIRED[2] |=> REQUIRED_STS[2];
   endproperty
   a_req_sts: assert property (p_req_sts) else $error("forced state not shown");
   property p_lim_range;
      @(posedge CLK) disable iff (RESET)
      lim_q[3] >= TMO_MIN_S && lim_q[3] <= TMO_MAX_S;
   endproperty
   a_lim_range: assert property (p_lim_range) else $error("limit out of range");
   property p_load;
      @(posedge CLK) disable iff (RESET)
      (st_q[0] == IDLE && EVT[0].start_home) |=> left_q[0] == $past(lim_q[0]);
   endproperty
   a_load: assert property (p_load) else $error("limit not loaded");
   property p_expire;
      @(posedge CLK) disable iff (RESET)
      (st_q[3] != IDLE && tick_q && left_q[3] <= 10'h001) |=> tmo_q[3] && st_q[3] == IDLE;
   endproperty
   a_expire: assert property (p_expire) else $error("timeout not taken");
   sequence s_offset_done;
      st_q[1] == OFFSET && EVT[1].offset_reached && !REF_SEARCH_EN[1] && !tick_q;
   endsequence
   property p_origin;
      @(posedge CLK) disable iff (RESET)
      s_offset_done |=> ##1 SET_ORIGIN[1];
   endproperty
   a_origin: assert property (p_origin) else $error("origin not set");
   property p_ref;
      @(posedge CLK) disable iff (RESET)
      (st_q[0] == REFSRCH) |-> $past(st_q[0]) inside {OFFSET, REFSRCH};
   endproperty
   a_ref: assert property (p_ref) else $error("search before offset");
   property p_ofs_range;
      @(posedge CLK) disable iff (RESET)
      ofs_q[0] >= OFS_MIN_UM && ofs_q[0] <= OFS_MAX_UM;
   endproperty
   a_ofs_range: assert property (p_ofs_range) else $error("offset out of range");
   property p_reset_lim;
      @(posedge CLK) $fell(RESET) |-> lim_q[0] == TMO_RST_XY_S && lim_q[2] == TMO_RST_ZA_S;
   endproperty
   a_reset_lim: assert property (p_reset_lim) else $error("bad reset limits");
   property p_travel;
      @(posedge CLK) disable iff (RESET)
      OFS_TRAVEL >= 19'sd0;
   endproperty
   a_travel: assert property (p_travel) else $error("gap underflow");
endmodule

// ==== hw/homing_pkg.sv ====
// shared constants and carrier types for the axis homing supervisor
package homing_pkg;
   // ------------------------------------------------------------
   // axes and timing
   // ------------------------------------------------------------
   localparam int NUM_AXES = 4;
   localparam int CLK_HZ = 100_000_000; // system clock rate
   localparam int SECOND_NS = 1_000_000_000; // one second in ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS; // cycles per second tick
   localparam logic [9:0] TMO_MIN_S = 10'h001; // least time limit, s
   localparam logic [9:0] TMO_MAX_OLD_S = 10'h078; // 120 s upper bound
   localparam logic [9:0] TMO_MAX_S = 10'h258; // 600 s extended bound
   localparam logic [9:0] TMO_RST_XY_S = 10'h03c; // 60 s for axes 0 and 1
   localparam logic [9:0] TMO_RST_ZA_S = 10'h028; // 40 s for axes 2 and 3
   // ------------------------------------------------------------
   // offset, in micrometres of the selected unit
   // ------------------------------------------------------------
   localparam logic signed [17:0] OFS_MIN_UM = -18'sd100; // -0.1 mm
   localparam logic signed [17:0] OFS_MAX_UM = 18'sd100000; // 100 mm
   localparam logic signed [17:0] OFS_RST_UM = 18'sd0;
   localparam logic signed [17:0] GAP_UM = 18'sd100; // 0.1 mm safety gap
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] axis; // target axis
      logic gate_we; // write gate setting
      logic gate_val;
      logic tmo_we; // write time limit
      logic [9:0] tmo_val;
      logic ofs_we; // write offset
      logic signed [17:0] ofs_val;
   } cfg_cmd_t;
   typedef struct packed {
      logic start_home; // start homing run
      logic start_range; // start range-measure run
      logic done; // run finished normally
      logic switch_released; // lower end switch left
      logic offset_reached; // offset move finished
   } run_evt_t;
   typedef enum logic [2:0] {IDLE, LEAVE, OFFSET, REFSRCH, RANGE} run_st_t;
endpackage

// ==== test/homing_host.sv ====
// host-side model that issues configuration writes to the supervisor
`timescale 1ns/1ps
module homing_host
   import homing_pkg::*;
(
   // clock
   input wire logic clk,
   // configuration toward the supervisor
   output homing_pkg::cfg_cmd_t cfg,
   // host owes a new learn run of the home position
   output logic relearn_due
);
   // ------------------------------------------------------------
   // one-cycle write strobes
   // ------------------------------------------------------------
   initial begin
      cfg = '0;
      relearn_due = 1'b0;
   end
   // kind 0 gate, 1 limit, 2 offset; strobe drops after one cycle
   task automatic put(input logic [1:0] ax, input int kind, input int val);
      cfg_cmd_t c;
      c = '0;
      c.axis = ax;
      c.gate_we = (kind == 0);
      c.gate_val = val[0];
      c.tmo_we = (kind == 1);
      c.tmo_val = val[9:0];
      c.ofs_we = (kind == 2);
      c.ofs_val = val[17:0];
      @(posedge clk);
      cfg <= c;
      // a learned home is stale once the offset moves
      if (kind == 2) begin
         relearn_due <= 1'b1;
      end
      @(posedge clk);
      cfg <= '0;
   endtask
endmodule

// ==== test/axis_homing_supervisor_bench.sv ====
// self-checking bench for the axis homing supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; $display("MISMATCH %s exp %0d got %0d", nm, ex, got); end end
module axis_homing_supervisor_bench;
   import homing_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int TICK = 10; // shortened second keeps runs brief
   logic CLK, RESET;
   cfg_cmd_t cfg;
   logic [1:0] qax;
   logic [3:0] force_req, ref_en, move_req;
   run_evt_t evt [4];
   logic [3:0] move_en, homed, req_sts, tmo_flag, run_act, set_org, ref_srch;
   logic signed [18:0] ofs_tr;
   logic [9:0] tmo_lim, tmo_left;
   logic cfg_rej, relearn;
   int n_fail = 0;
   int samples_checked = 0;
   axis_homing_supervisor #(.SEC_TICKS(TICK)) u_dut (.CLK(CLK), .RESET(RESET), .CFG(cfg),
      .QUERY_AXIS(qax), .FORCE_REQUIRED(force_req), .REF_SEARCH_EN(ref_en),
      .MOVE_REQ(move_req), .EVT(evt), .MOVE_EN(move_en), .HOMED(homed),
      .REQUIRED_STS(req_sts), .TIMEOUT_FLAG(tmo_flag), .RUN_ACTIVE(run_act),
      .SET_ORIGIN(set_org), .REF_SEARCH(ref_srch), .OFS_TRAVEL(ofs_tr),
      .TMO_LIMIT(tmo_lim), .TMO_LEFT(tmo_left), .CFG_REJECT(cfg_rej));
   homing_host u_host (.clk(CLK), .cfg(cfg), .relearn_due(relearn));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // waits n edges, then lets the registered outputs settle before a look
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // one-cycle event pulse on one axis
   task automatic ev(input int ax, input logic [4:0] v);
      @(posedge CLK);
      evt[ax] <= v;
      @(posedge CLK);
      evt[ax] <= '0;
   endtask
   // counts strobes over six edges; sel 4 watches the reject strobe
   task automatic pulses(input int sel, output int n);
      n = 0;
      repeat (6) begin
         @(posedge CLK);
         #1;
         if (sel == 4 ? cfg_rej === 1'b1 : set_org[sel] === 1'b1) n++;
      end
   endtask
   // full homing walk, optionally with reference search
   task automatic home(input int ax, input logic use_ref);
      int n;
      ev(ax, 5'h10);
      cyc(3);
      `CHK("run_active", 1'b1, run_act[ax])
      ev(ax, 5'h02);
      ev(ax, 5'h01);
      pulses(ax, n);
      `CHK("origin_after_offset", use_ref ? 0 : 1, n)
      if (use_ref) begin
         `CHK("ref_search", 1'b1, ref_srch[ax])
         ev(ax, 5'h04);
         pulses(ax, n);
         `CHK("origin_after_ref", 1, n)
      end
      `CHK("homed", 1'b1, homed[ax])
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      for (int ax = 0; ax < 4; ax++) begin
         @(posedge CLK);
         qax <= ax[1:0];
         cyc(3);
         `CHK("limit_rst", (ax < 2) ? 60 : 40, tmo_lim)
         `CHK("travel_rst", 100, ofs_tr)
      end
      `CHK("move_free", 4'hf, move_en)
   endtask
   task automatic t_gate();
      u_host.put(2'h1, 0, 1);
      @(posedge CLK);
      force_req <= 4'h4;
      cyc(4);
      `CHK("required", 4'h6, req_sts)
      `CHK("move_blocked", 4'h9, move_en)
      home(1, 1'b0);
      cyc(3);
      `CHK("move_homed", 4'hb, move_en)
      @(posedge CLK);
      force_req <= '0;
      cyc(4);
      `CHK("move_all", 4'hf, move_en)
      u_host.put(2'h1, 0, 0);
      cyc(3);
      `CHK("required_off", 4'h0, req_sts)
   endtask
   // limits on axis 3: both bounds and one step past each
   task automatic t_limits();
      int v[4] = '{0, 601, 600, 1};
      int lim[4] = '{40, 40, 600, 1};
      int n;
      @(posedge CLK);
      qax <= 2'h3;
      for (int i = 0; i < 4; i++) begin
         u_host.put(2'h3, 1, v[i]);
         pulses(4, n);
         `CHK("tmo_reject", (i < 2) ? 1 : 0, n)
         `CHK("tmo_limit", lim[i], tmo_lim)
      end
   endtask
   // offsets on axis 0, then a reference-mark homing run
   task automatic t_offset();
      int v[5] = '{5000, -101, -100, 100001, 100000};
      int tr[5] = '{5100, 5100, 0, 0, 100100};
      int n;
      @(posedge CLK);
      qax <= 2'h0;
      ref_en <= 4'h1;
      for (int i = 0; i < 5; i++) begin
         u_host.put(2'h0, 2, v[i]);
         pulses(4, n);
         `CHK("ofs_reject", i % 2, n)
         `CHK("travel", tr[i], ofs_tr)
      end
      `CHK("relearn", 1'b1, relearn)
      home(0, 1'b1);
   endtask
   // remaining time after a range run, then a homing run that expires
   task automatic t_timer();
      logic [9:0] left;
      @(posedge CLK);
      qax <= 2'h3;
      u_host.put(2'h3, 1, 10);
      ev(3, 5'h08);
      cyc(35);
      ev(3, 5'h04);
      cyc(4);
      left = tmo_left;
      `CHK("left_span", 1'b1, (left < 10'h00a) && (left > 10'h005))
      cyc(30);
      `CHK("left_held", left, tmo_left)
      u_host.put(2'h3, 1, 2);
      ev(3, 5'h10);
      cyc(5);
      `CHK("no_early_expiry", 1'b0, tmo_flag[3])
      cyc(40);
      `CHK("expired", 1'b1, tmo_flag[3])
      `CHK("stopped", 1'b0, run_act[3])
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      repeat (5000) @(posedge CLK);
      n_fail++;
      conclude();
   end
   initial begin
      RESET = 1'b1;
      qax = '0;
      force_req = '0;
      ref_en = '0;
      move_req = 4'hf;
      for (int i = 0; i < 4; i++) evt[i] = '0;
      repeat (16) @(posedge CLK);
      RESET <= 1'b0;
      t_reset();
      t_gate();
      t_limits();
      t_offset();
      t_timer();
      conclude();
   end
endmodule
